// *** src/rtcalm_ctrl.sv ***
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
module rtcalm_ctrl #(
  parameter int ADDR_W = 4,
  parameter int PRE_W = 16
) (
  // clock and resets
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sys_rst_n,
  // axi4-lite write address and data
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // axi4-lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // axi4-lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // timekeeper state
  input wire logic [PRE_W-1:0] clks_to_rollover,
  input wire logic half_tick,
  input wire logic sec_tick,
  input wire logic sec_units_eq,
  input wire logic sec_tens_eq,
  input wire logic min_units_eq,
  input wire logic min_tens_eq,
  input wire logic hour_eq,
  input wire logic wday_eq,
  input wire logic mday_eq,
  input wire logic month_eq,
  input wire logic alarm_feb29,
  input wire logic leap_year,
  // alarm outputs
  output logic alarm_pulse,
  output logic alarm_event
);
  import rtcalm_pkg::*;

  typedef struct packed {
    logic enable;
    logic chime;
    logic pulse;
    logic unsafe;
    logic [MASK_W-1:0] mask;
    logic [RPT_W-1:0] rpt;
    logic evt;
    logic aw_got;
    logic [ADDR_W-1:0] waddr;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [15:0] rdata;
  } rtcalm_st_t;

  localparam rtcalm_st_t ST_RST = '0;

  rtcalm_st_t st_r, st_nxt;
  logic hit, fire, aw_hs, w_hs, do_write, hit_reg, ar_hs;
  logic [ADDR_W-1:0] eff_addr;
  logic [15:0] eff_data, view;
  logic [1:0] eff_strb;

  // =========================================================
  // interval decode
  rtcalm_match u_match (
    .interval_sel(st_r.mask),
    .half_tick(half_tick),
    .sec_tick(sec_tick),
    .sec_units_eq(sec_units_eq),
    .sec_tens_eq(sec_tens_eq),
    .min_units_eq(min_units_eq),
    .min_tens_eq(min_tens_eq),
    .hour_eq(hour_eq),
    .wday_eq(wday_eq),
    .mday_eq(mday_eq),
    .month_eq(month_eq),
    .alarm_feb29(alarm_feb29),
    .leap_year(leap_year),
    .hit(hit)
  );

  // =========================================================
  // bus handshakes
  assign s_axi_awready = ~st_r.aw_got & ~st_r.bvalid;
  assign s_axi_wready = ~st_r.w_got & ~st_r.bvalid;
  assign s_axi_arready = ~st_r.rvalid;
  assign aw_hs = s_axi_awvalid & s_axi_awready;
  assign w_hs = s_axi_wvalid & s_axi_wready;
  assign ar_hs = s_axi_arvalid & s_axi_arready;
  assign do_write = (st_r.aw_got | aw_hs) & (st_r.w_got | w_hs);
  assign eff_addr = st_r.aw_got ? st_r.waddr : s_axi_awaddr;
  assign eff_data = st_r.w_got ? st_r.wdata : s_axi_wdata[15:0];
  assign eff_strb = st_r.w_got ? st_r.wstrb : s_axi_wstrb[1:0];
  assign hit_reg = do_write & (eff_addr == ADDR_W'(ALARM_CONTROL_OFS));
  assign fire = st_r.enable & hit;

  // upper half of read data is always zero, bit 13 shows the live pulse
  assign view = {st_r.enable, st_r.chime, st_r.pulse, st_r.unsafe,
                 st_r.mask, st_r.rpt};

  // =========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.evt = 1'b0;
    st_nxt.unsafe = (clks_to_rollover <= PRE_W'(SAFE_MARGIN));

    // software write, low byte then high byte
    if (hit_reg && eff_strb[0]) begin
      st_nxt.rpt = eff_data[RPT_LSB +: RPT_W];
    end
    if (hit_reg && eff_strb[1]) begin
      st_nxt.mask = eff_data[MASK_LSB +: MASK_W];
      st_nxt.chime = eff_data[CHIME_BIT];
      st_nxt.enable = eff_data[ENABLE_BIT];
      if (!st_r.enable) begin
        st_nxt.pulse = eff_data[PIV_BIT];
      end
    end

    // alarm event applied on top of a same-cycle write
    if (fire) begin
      st_nxt.evt = 1'b1;
      st_nxt.pulse = ~st_r.pulse;
      if (st_r.rpt != '0) begin
        st_nxt.rpt = st_r.rpt - 8'h01;
      end else if (st_r.chime) begin
        st_nxt.rpt = RPT_MAX;
      end else begin
        st_nxt.rpt = st_r.rpt;
        st_nxt.enable = 1'b0;
      end
    end

    // write channel capture
    if (aw_hs && !do_write) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.waddr = s_axi_awaddr;
    end
    if (w_hs && !do_write) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata[15:0];
      st_nxt.wstrb = s_axi_wstrb[1:0];
    end
    if (do_write) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = hit_reg ? RESP_OKAY : RESP_DECERR;
    end else if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel
    if (ar_hs) begin
      st_nxt.rvalid = 1'b1;
      if (s_axi_araddr == ADDR_W'(ALARM_CONTROL_OFS)) begin
        st_nxt.rdata = view;
        st_nxt.rresp = RESP_OKAY;
      end else begin
        st_nxt.rdata = '0;
        st_nxt.rresp = RESP_DECERR;
      end
    end else if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end

    // system reset clears the bus side and the alarm event only
    if (!sys_rst_n) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b0;
      st_nxt.rvalid = 1'b0;
      st_nxt.evt = 1'b0;
    end
  end

  // =========================================================
  // state register, cleared by power-on reset only
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_bvalid = st_r.bvalid;
  assign s_axi_bresp = st_r.bresp;
  assign s_axi_rvalid = st_r.rvalid;
  assign s_axi_rdata = {16'h0000, st_r.rdata};
  assign s_axi_rresp = st_r.rresp;
  assign alarm_pulse = st_r.pulse;
  assign alarm_event = st_r.evt;

  // =========================================================
  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence clean_fire_s;
    fire && !hit_reg;
  endsequence

  sequence zero_fire_s;
    clean_fire_s ##0 st_r.rpt == 8'h00;
  endsequence

  gated_by_enable_a: assert property (alarm_event |-> $past(st_r.enable))
    else $error("alarm event while disabled");

  chime_wrap_a: assert property (zero_fire_s ##0 st_r.chime |=>
    st_r.rpt == 8'hff && st_r.enable)
    else $error("repeat count did not wrap to 0xff");

  count_stop_a: assert property (zero_fire_s ##0 !st_r.chime |=>
    st_r.rpt == 8'h00)
    else $error("repeat count moved past zero");

  piv_write_a: assert property ((hit_reg && eff_strb[1] && !st_r.enable)
    |=> st_r.pulse == $past(eff_data[PIV_BIT]))
    else $error("pulse level not taken from written value");

  piv_locked_a: assert property ((st_r.enable && !fire) |=>
    st_r.pulse == $past(st_r.pulse))
    else $error("pulse level changed by write while enabled");

  unsafe_flag_a: assert property (##1 st_r.unsafe ==
    ($past(clks_to_rollover) <= PRE_W'(SAFE_MARGIN)))
    else $error("rollover flag wrong for prescaler distance");

  reserved_quiet_a: assert property ((st_r.mask > IVL_YEAR) |=>
    !alarm_event)
    else $error("alarm from a reserved interval code");

  auto_disable_a: assert property (zero_fire_s ##0 !st_r.chime |=>
    !st_r.enable ##1 !alarm_event)
    else $error("enable not cleared after last alarm");

  feb29_leap_a: assert property ((st_r.mask == IVL_YEAR &&
    alarm_feb29 && !leap_year) |-> !hit)
    else $error("february 29 alarm fired outside a leap year");

  sys_keep_a: assert property ((!sys_rst_n && !fire && !hit_reg) |=>
    st_r.rpt == $past(st_r.rpt) && st_r.mask == $past(st_r.mask))
    else $error("system reset disturbed alarm control");

  upper_zero_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:16] == 16'h0000)
    else $error("upper half of read data not zero");

  pulse_toggle_a: assert property (clean_fire_s |=>
    alarm_event && alarm_pulse != $past(alarm_pulse))
    else $error("alarm did not toggle the pulse");

endmodule // rtcalm_ctrl

// *** src/rtcalm_match.sv ***
`timescale 1ns/10ps
module rtcalm_match (
  // interval selection
  input wire logic [3:0] interval_sel,
  // calendar ticks and compare results
  input wire logic half_tick,
  input wire logic sec_tick,
  input wire logic sec_units_eq,
  input wire logic sec_tens_eq,
  input wire logic min_units_eq,
  input wire logic min_tens_eq,
  input wire logic hour_eq,
  input wire logic wday_eq,
  input wire logic mday_eq,
  input wire logic month_eq,
  input wire logic alarm_feb29,
  input wire logic leap_year,
  // match result
  output logic hit
);
  import rtcalm_pkg::*;

  logic m10s, m1m, m10m, m1h, m1d;

  // =========================================================
  // cascaded field compares
  always_comb begin
    m10s = sec_tick & sec_units_eq;
    m1m = m10s & sec_tens_eq;
    m10m = m1m & min_units_eq;
    m1h = m10m & min_tens_eq;
    m1d = m1h & hour_eq;
    unique case (interval_sel)
      IVL_HALF_SEC: hit = half_tick;
      IVL_SEC: hit = sec_tick;
      IVL_10_SEC: hit = m10s;
      IVL_MIN: hit = m1m;
      IVL_10_MIN: hit = m10m;
      IVL_HOUR: hit = m1h;
      IVL_DAY: hit = m1d;
      IVL_WEEK: hit = m1d & wday_eq;
      IVL_MONTH: hit = m1d & mday_eq;
      IVL_YEAR: hit = m1d & mday_eq & month_eq & (~alarm_feb29 | leap_year);
      default: hit = 1'b0;
    endcase
  end

endmodule // rtcalm_match

// *** src/rtcalm_pkg.sv ***
package rtcalm_pkg;

  // =========================================================
  // register map
  localparam logic [3:0] ALARM_CONTROL_OFS = 4'h0;
  localparam logic [15:0] ALARM_CONTROL_RST = 16'h0000;

  // =========================================================
  // field layout
  localparam int ENABLE_BIT = 15;
  localparam int CHIME_BIT = 14;
  localparam int PIV_BIT = 13;
  localparam int UNSAFE_BIT = 12;
  localparam int MASK_LSB = 8;
  localparam int MASK_W = 4;
  localparam int RPT_LSB = 0;
  localparam int RPT_W = 8;
  localparam logic [7:0] RPT_MAX = 8'hff;

  // =========================================================
  // interval codes
  localparam logic [3:0] IVL_HALF_SEC = 4'h0;
  localparam logic [3:0] IVL_SEC = 4'h1;
  localparam logic [3:0] IVL_10_SEC = 4'h2;
  localparam logic [3:0] IVL_MIN = 4'h3;
  localparam logic [3:0] IVL_10_MIN = 4'h4;
  localparam logic [3:0] IVL_HOUR = 4'h5;
  localparam logic [3:0] IVL_DAY = 4'h6;
  localparam logic [3:0] IVL_WEEK = 4'h7;
  localparam logic [3:0] IVL_MONTH = 4'h8;
  localparam logic [3:0] IVL_YEAR = 4'h9;

  // =========================================================
  // timing and bus answers
  localparam int SAFE_MARGIN = 32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage

// *** test/rtc_alarm_control_bench.sv ***
`timescale 1ns/10ps
module rtc_alarm_control_bench;
  import rtcalm_pkg::*;
  // ==========================================================
  // clock, resets and design ports
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sys_rst_n = 1'b1;
  logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  logic awr, wr_rdy, bv, arr, rv, pulse, evt;
  logic [3:0] awa = 4'h0, ara = 4'h0, strb = 4'h0;
  logic [31:0] wd = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [15:0] roll = 16'h1000;
  // ticks and compares: half,sec,su,st,mu,mt,hr,wd,md,mo,feb29,leap
  logic [11:0] tk = 12'h0;
  // bench model of the control register
  logic en = 1'b0, ch = 1'b0, pv = 1'b0;
  logic [3:0] mk = 4'h0;
  logic [7:0] cnt = 8'h0;
  logic [31:0] seed = 32'd84978;
  int bad_count = 0, checked = 0, cyc = 0;

  always #12.5 clk = ~clk;

  rtcalm_ctrl dut (.clk(clk), .rst_n(rst_n), .sys_rst_n(sys_rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
    .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_wdata(wd),
    .s_axi_wstrb(strb), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .clks_to_rollover(roll),
    .half_tick(tk[11]), .sec_tick(tk[10]), .sec_units_eq(tk[9]),
    .sec_tens_eq(tk[8]), .min_units_eq(tk[7]), .min_tens_eq(tk[6]),
    .hour_eq(tk[5]), .wday_eq(tk[4]), .mday_eq(tk[3]),
    .month_eq(tk[2]), .alarm_feb29(tk[1]), .leap_year(tk[0]),
    .alarm_pulse(pulse), .alarm_event(evt));

  // ==========================================================
  // expectation helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction

  function automatic logic match(input logic [3:0] m,
                                 input logic [11:0] t);
    logic a2, a6, a8;
    a2 = t[10] & t[9];
    a6 = a2 & t[8] & t[7] & t[6] & t[5];
    a8 = a6 & t[3];
    case (m)
      4'h0: return t[11];
      4'h1: return t[10];
      4'h2: return a2;
      4'h3: return a2 & t[8];
      4'h4: return a2 & t[8] & t[7];
      4'h5: return a2 & t[8] & t[7] & t[6];
      4'h6: return a6;
      4'h7: return a6 & t[4];
      4'h8: return a8;
      4'h9: return a8 & t[2] & (!t[1] | t[0]);
      default: return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] word();
    return {16'h0, en, ch, pv, roll <= 16'd32, mk, cnt};
  endfunction

  // ==========================================================
  // compare, bus and alarm tasks
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d,
                    input logic [1:0] e);
    @(posedge clk);
    awv <= 1'b1;
    wv <= 1'b1;
    awa <= a;
    wd <= {16'h0, d};
    strb <= 4'h3;
    br <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (bv !== 1'b1);
    br <= 1'b0;
    chk("bresp", bresp, e);
    if (e == RESP_OKAY) begin
      if (!en) pv = d[13];
      en = d[15];
      ch = d[14];
      mk = d[11:8];
      cnt = d[7:0];
    end
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] ed,
                       input logic [1:0] e);
    @(posedge clk);
    arv <= 1'b1;
    ara <= a;
    rr <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1);
    rr <= 1'b0;
    chk("rdata", rdata, ed);
    chk("rresp", rresp, e);
  endtask

  task automatic fire(input logic [11:0] t);
    logic h;
    h = en & match(mk, t);
    @(posedge clk);
    tk <= t;
    @(posedge clk);
    tk <= {2'b00, t[9:0]};
    #1;
    chk("alarm_event", evt, h);
    if (h) begin
      pv = !pv;
      if (cnt != 8'h00) cnt = cnt - 8'h01;
      else if (ch) cnt = RPT_MAX;
      else en = 1'b0;
    end
    chk("alarm_pulse", pulse, pv);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      results();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rdchk(4'h0, 32'h0, RESP_OKAY);
    wr(4'h4, 16'hffff, RESP_DECERR);
    rdchk(4'h8, 32'h0, RESP_DECERR);
    rdchk(4'h0, word(), RESP_OKAY);
    wr(4'h0, 16'h2000, RESP_OKAY);
    chk("alarm_pulse", pulse, 1'b1);
    for (int i = 0; i < 48; i++) begin
      seed = xs(seed);
      wr(4'h0, {1'b1, seed[0], seed[1], 1'b0, i[3:0],
         (i % 3 == 0) ? 8'h00 : seed[15:8]}, RESP_OKAY);
      fire({|seed[21:20], |seed[23:22], seed[31:24] | seed[30:23],
            seed[19:18]});
      rdchk(4'h0, word(), RESP_OKAY);
    end
    wr(4'h0, {3'b110, pv, 12'h903}, RESP_OKAY);
    fire(12'hffe);
    fire(12'hfff);
    wr(4'h0, {3'b000, pv, 12'h000}, RESP_OKAY);
    fire(12'h800);
    for (int k = 0; k < 4; k++) begin
      roll <= (k == 3) ? 16'h1000 : 16'd31 + 16'(k);
      repeat (2) @(posedge clk);
      rdchk(4'h0, word(), RESP_OKAY);
      // near a rollover software reads again; the bench reads exactly twice and checks both
      rdchk(4'h0, word(), RESP_OKAY);
    end
    wr(4'h0, {3'b011, pv, 12'h5a7}, RESP_OKAY);
    @(posedge clk);
    sys_rst_n <= 1'b0;
    @(posedge clk);
    sys_rst_n <= 1'b1;
    rdchk(4'h0, word(), RESP_OKAY);
    results();
  end
endmodule // rtc_alarm_control_bench
